// ---- hdl/srp_packetizer.sv ----
/*
  Serial receive packetizer: groups host bytes into link transfers by
  one of five modes and splits them at the usable transfer payload.
  Assumes receive bytes, pipe state and link handshakes come from logic
  on CORE_CLK; registers reached over a plain strobe port.
*/
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
// Operation
// RULE1: Only open-pipe host bytes are packetized
// RULE2: Bytes delivered once, unaltered, in order
// RULE3: Poll received bytes at most every 20 us
// RULE4: Immediate mode sends everything when link accepts
// RULE5: Anticipate sends once target length reached
// RULE6: Anticipate sends buffered bytes on timeout
// RULE7: Reset: anticipate, 5 ms, 20 bytes
// RULE8: Host keeps timeout 1-255, length 1-128
// RULE9: Fixed mode sends exactly target length
// RULE10: Variable mode strips count, sends that many
// RULE11: Variable count above 128 clamped to 128
// RULE12: End byte sends buffer including end byte
// RULE13: End byte resets to 0x0d, any value
// RULE14: Small payload: send one payload without end
// RULE15: Large payload: full buffer sends 128 bytes
// RULE16: Payload equals transfer unit minus three
// RULE17: Long packets split, full pieces then remainder
// RULE18: Host picks timeout to suit baud rate
// RULE19: Mode codes 0 to 4 as listed
// RULE20: Command carries mode, timeout, length bytes
// RULE21: Timeout starts on first byte, cleared on send
// RULE22: Hold transmission while link cannot accept
module srp_packetizer #(
  parameter int MS_CYC = srp_pkg::MS_CYC  // Core cycles per millisecond
) (
  input  wire logic       CORE_CLK,       // Core clock, 10 MHz
  input  wire logic       ARST_N,         // Asynchronous reset, active low
  input  wire logic [3:0] REG_ADDR,       // Register offset
  input  wire logic [7:0] REG_WDATA,      // Register write data
  input  wire logic       REG_WR,         // Write strobe
  input  wire logic       REG_RD,         // Read strobe
  output logic      [7:0] REG_RDATA,      // Read data, cycle after strobe
  input  wire logic       PIPE_OPEN,      // Data pipe open
  input  wire logic       RX_VALID,       // Host byte available
  input  wire logic [7:0] RX_DATA,        // Host byte
  output logic            RX_READY,       // Byte taken when valid
  output logic            BYP_VALID,      // Command-mode byte passed on
  output logic      [7:0] BYP_DATA,       // Command-mode byte
  input  wire logic [15:0] LINK_MTU,      // Negotiated max_transfer_unit
  input  wire logic       LINK_READY,     // Link accepts a new transfer
  output logic            TX_VALID,       // Transfer byte valid
  output logic      [7:0] TX_DATA,        // Transfer byte
  output logic            TX_LAST,        // Last byte of a transfer
  input  wire logic       TX_READY        // Link takes the byte
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]          mem [0:127];       // Receive buffer
  logic [6:0]          wr_ptr;            // Next write slot
  logic [6:0]          rd_ptr;            // Next read slot
  logic [7:0]          count;             // Bytes buffered
  logic [7:0]          cfg_mode;          // Packetization mode
  logic [7:0]          cfg_wait;          // Timeout, ms
  logic [7:0]          cfg_length;        // Target length
  logic [7:0]          cfg_eop;           // end_of_packet_byte
  logic [7:0]          var_left;          // Payload bytes still expected
  logic [7:0]          ready_len;         // Complete variable packet length
  logic [7:0]          eop_len;           // Bytes up to the end byte
  logic [7:0]          ms_elapsed;        // Timeout progress, ms
  logic [7:0]          send_left;         // Bytes left in the packet
  logic [7:0]          piece_left;        // Bytes left in the transfer
  logic [7:0]          send_len;          // Length chosen at start
  logic                want;              // Mode asks for a send
  logic                start;             // Send begins this cycle
  logic                poll_tick;         // Poll interval pulse
  logic                ms_tick;           // Millisecond pulse
  logic                timer_clr;         // Hold the timeout at zero
  logic                hold;              // Stall input for framing
  logic                is_prefix;         // Next byte is a count
  logic                take;              // Byte accepted in pipe mode
  logic                push;              // Byte written to buffer
  logic                pop;               // Byte moved to output
  logic [15:0]         payload;           // Usable transfer payload
  srp_pkg::srp_state_t state;             // Send engine state

  ////////////////////////////////////////////////////////////////////////////
  // Timing enables
  srp_tick_div #(.CYC(srp_pkg::POLL_CYC)) u_poll (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .clr    (1'b0),
    .tick   (poll_tick)
  );

  assign timer_clr = (count == 8'h00) || (state != srp_pkg::ST_IDLE); // RULE21

  srp_tick_div #(.CYC(MS_CYC)) u_ms (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .clr    (timer_clr),
    .tick   (ms_tick)
  );

  // Milliseconds since the first byte entered an empty buffer or the last send ended
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ms_elapsed <= 8'h00;
    end else if (timer_clr) begin
      ms_elapsed <= 8'h00;                 // RULE21
    end else if (ms_tick && ms_elapsed != 8'hff) begin
      ms_elapsed <= ms_elapsed + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  // Configuration writes; a mode write drops partial framing state
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_mode   <= srp_pkg::RST_MODE;     // RULE7
      cfg_wait   <= srp_pkg::RST_WAIT;     // RULE7
      cfg_length <= srp_pkg::RST_LENGTH;   // RULE7
      cfg_eop    <= srp_pkg::RST_EOP;      // RULE13
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        srp_pkg::REG_MODE:   cfg_mode   <= REG_WDATA; // RULE20
        srp_pkg::REG_WAIT:   cfg_wait   <= REG_WDATA; // RULE20
        srp_pkg::REG_LENGTH: cfg_length <= REG_WDATA; // RULE20
        srp_pkg::REG_EOP:    cfg_eop    <= REG_WDATA; // RULE13
        default: ;                                    // Read-only or unmapped
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        srp_pkg::REG_MODE:   REG_RDATA <= cfg_mode;
        srp_pkg::REG_WAIT:   REG_RDATA <= cfg_wait;
        srp_pkg::REG_LENGTH: REG_RDATA <= cfg_length;
        srp_pkg::REG_EOP:    REG_RDATA <= cfg_eop;
        srp_pkg::REG_COUNT:  REG_RDATA <= count;
        srp_pkg::REG_STATE:  REG_RDATA <= {6'h00, state};
        default:             REG_RDATA <= 8'h00;  // Unmapped reads zero
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input side
  // Usable payload, at least one byte for a degenerate unit
  assign payload = (LINK_MTU > srp_pkg::MTU_HDR) ? LINK_MTU - srp_pkg::MTU_HDR
                                                 : 16'h0001; // RULE16

  // Framing modes take no new byte while a framed packet waits or goes out
  assign hold = ((cfg_mode == srp_pkg::MODE_VARIABLE) || (cfg_mode == srp_pkg::MODE_END_BYTE))
              && ((state != srp_pkg::ST_IDLE) || (ready_len != 8'h00) || (eop_len != 8'h00));
  assign is_prefix = (cfg_mode == srp_pkg::MODE_VARIABLE) && (var_left == 8'h00);
  assign RX_READY  = !PIPE_OPEN || (!hold && (count != srp_pkg::BUF_DEPTH)); // RULE1
  assign take      = RX_VALID && RX_READY && PIPE_OPEN;
  assign push      = take && !is_prefix;                                  // RULE10

  // Command-mode bytes bypass the packetizer unchanged
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BYP_VALID <= 1'b0;
      BYP_DATA  <= 8'h00;
    end else begin
      BYP_VALID <= RX_VALID && !PIPE_OPEN;                                // RULE1
      if (RX_VALID && !PIPE_OPEN) begin
        BYP_DATA <= RX_DATA;                                              // RULE1
      end
    end
  end

  // Buffer write side
  always_ff @(posedge CORE_CLK) begin
    if (push) begin
      mem[wr_ptr] <= RX_DATA;                                             // RULE2
    end
  end

  // Pointers and fill count
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      count  <= 8'h00;
    end else begin
      if (push) wr_ptr <= wr_ptr + 7'h01;
      if (pop)  rd_ptr <= rd_ptr + 7'h01;                                 // RULE2
      count <= count + {7'h00, push} - {7'h00, pop};
    end
  end

  // Variable-mode count bytes and completed packet length
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      var_left  <= 8'h00;
      ready_len <= 8'h00;
    end else if (REG_WR && REG_ADDR == srp_pkg::REG_MODE) begin
      var_left  <= 8'h00;
      ready_len <= 8'h00;
    end else begin
      if (take && is_prefix) begin
        var_left <= (RX_DATA > srp_pkg::BUF_DEPTH) ? srp_pkg::BUF_DEPTH : RX_DATA; // RULE11
      end else if (push && var_left != 8'h00) begin
        var_left <= var_left - 8'h01;
      end
      if (start) begin
        ready_len <= 8'h00;
      end else if (push && cfg_mode == srp_pkg::MODE_VARIABLE && var_left == 8'h01) begin
        ready_len <= count + 8'h01;                                       // RULE10
      end
    end
  end

  // End-byte position, corrected for a send starting in the same cycle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      eop_len <= 8'h00;
    end else if ((REG_WR && REG_ADDR == srp_pkg::REG_MODE) || (start && eop_len != 8'h00)) begin
      eop_len <= 8'h00;
    end else if (push && cfg_mode == srp_pkg::MODE_END_BYTE && RX_DATA == cfg_eop
                 && eop_len == 8'h00) begin
      eop_len <= count + 8'h01 - (start ? send_len : 8'h00);             // RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Send decision, evaluated on each poll pulse
  always_comb begin
    want     = 1'b0;
    send_len = count;
    unique case (cfg_mode)
      srp_pkg::MODE_ANTICIPATE: begin
        want = (count >= cfg_length)                                      // RULE5
            || (ms_elapsed >= cfg_wait);                                  // RULE6
      end
      srp_pkg::MODE_FIXED: begin
        want     = (count >= cfg_length);                                 // RULE9
        send_len = cfg_length;                                            // RULE9
      end
      srp_pkg::MODE_VARIABLE: begin
        if (ready_len != 8'h00) begin
          want     = 1'b1;
          send_len = ready_len;                                           // RULE10
        end else begin
          want = (var_left == 8'h00);      // Leftover from a mode change
        end
      end
      srp_pkg::MODE_END_BYTE: begin
        if (eop_len != 8'h00) begin
          want     = 1'b1;
          send_len = eop_len;                                             // RULE12
        end else if (payload < {8'h00, srp_pkg::BUF_DEPTH}) begin
          want     = ({8'h00, count} >= payload);                         // RULE14
          send_len = payload[7:0];                                        // RULE14
        end else begin
          want = (count == srp_pkg::BUF_DEPTH);                           // RULE15
        end
      end
      default: begin
        want = 1'b1;                       // Immediate and unknown codes
      end
    endcase
  end

  // Start only when polled, link free and data present
  assign start = (state == srp_pkg::ST_IDLE) && poll_tick && LINK_READY // RULE3 RULE22
              && (count != 8'h00) && want;                                // RULE4

  // Transfer size: full payload pieces, then the remainder
  function automatic logic [7:0] fn_piece(input logic [7:0] n, input logic [15:0] p);
    fn_piece = ({8'h00, n} > p) ? p[7:0] : n;
  endfunction : fn_piece

  assign pop = (state == srp_pkg::ST_SEND) && (piece_left != 8'h00) && (!TX_VALID || TX_READY);

  // Send engine
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state      <= srp_pkg::ST_IDLE;
      send_left  <= 8'h00;
      piece_left <= 8'h00;
    end else begin
      unique case (state)
        srp_pkg::ST_IDLE: begin
          if (start) begin
            send_left  <= send_len;
            piece_left <= fn_piece(send_len, payload);                    // RULE17
            state      <= srp_pkg::ST_SEND;
          end
        end
        srp_pkg::ST_SEND: begin
          if (pop) begin
            send_left  <= send_left - 8'h01;
            piece_left <= piece_left - 8'h01;
          end else if (piece_left == 8'h00 && (!TX_VALID || TX_READY)) begin
            state <= (send_left == 8'h00) ? srp_pkg::ST_IDLE : srp_pkg::ST_LINK;
          end
        end
        srp_pkg::ST_LINK: begin
          if (LINK_READY) begin                                           // RULE22
            piece_left <= fn_piece(send_left, payload);                   // RULE17
            state      <= srp_pkg::ST_SEND;
          end
        end
        default: state <= srp_pkg::ST_IDLE;
      endcase
    end
  end

  // Output byte register
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_VALID <= 1'b0;
      TX_DATA  <= 8'h00;
      TX_LAST  <= 1'b0;
    end else if (pop) begin
      TX_VALID <= 1'b1;
      TX_DATA  <= mem[rd_ptr];                                            // RULE2
      TX_LAST  <= (piece_left == 8'h01);                                  // RULE17
    end else if (TX_READY) begin
      TX_VALID <= 1'b0;
      TX_LAST  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  AST_BYPASS: assert property (RX_VALID && !PIPE_OPEN |=> BYP_VALID && BYP_DATA == $past(RX_DATA)
                               && count == $past(count) - {7'h00, $past(pop)}) // RULE1
    else $error("command-mode byte not bypassed");
  AST_COUNT: assert property (push && !pop |=> count == $past(count) + 8'h01) // RULE2
    else $error("buffer count lost a byte");
  AST_POLL: assert property (state == srp_pkg::ST_IDLE ##1 state != srp_pkg::ST_IDLE
                             |-> $past(poll_tick) && $past(LINK_READY)) // RULE3
    else $error("send began off a poll pulse");
  AST_IMM: assert property (start && cfg_mode == srp_pkg::MODE_IMMEDIATE
                            |=> send_left == $past(count)) // RULE4
    else $error("immediate mode did not send all bytes");
  AST_ANT: assert property (state == srp_pkg::ST_IDLE && poll_tick && LINK_READY
                            && cfg_mode == srp_pkg::MODE_ANTICIPATE && count != 8'h00
                            && (count >= cfg_length || ms_elapsed >= cfg_wait)
                            |=> state == srp_pkg::ST_SEND) // RULE6
    else $error("anticipate mode missed a send");
  AST_RST: assert property ($rose(ARST_N) |-> cfg_mode == srp_pkg::RST_MODE
                            && cfg_wait == srp_pkg::RST_WAIT && cfg_eop == srp_pkg::RST_EOP
                            && cfg_length == srp_pkg::RST_LENGTH) // RULE7
    else $error("wrong configuration after reset");
  AST_FIXED: assert property (start && cfg_mode == srp_pkg::MODE_FIXED
                              |=> send_left == $past(cfg_length)) // RULE9
    else $error("fixed mode sent a wrong length");
  AST_CLAMP: assert property (take && is_prefix && RX_DATA > srp_pkg::BUF_DEPTH
                              |=> var_left == srp_pkg::BUF_DEPTH) // RULE11
    else $error("variable count not clamped");
  AST_PIECE: assert property (state == srp_pkg::ST_LINK && LINK_READY
                              |=> {8'h00, piece_left} <= payload && piece_left != 8'h00) // RULE17
    else $error("transfer piece exceeds payload");
  AST_HOLD: assert property (state == srp_pkg::ST_LINK && !LINK_READY
                             |=> state == srp_pkg::ST_LINK && !TX_VALID) // RULE22
    else $error("sent while link was busy");

  COV_ANT: cover property (start && cfg_mode == srp_pkg::MODE_ANTICIPATE && ms_elapsed >= cfg_wait);
  COV_VAR: cover property (start && cfg_mode == srp_pkg::MODE_VARIABLE && ready_len != 8'h00);
  COV_EOP: cover property (start && cfg_mode == srp_pkg::MODE_END_BYTE && eop_len != 8'h00);
  COV_SPLIT: cover property (state == srp_pkg::ST_LINK ##[1:40] state == srp_pkg::ST_SEND);

endmodule : srp_packetizer

// ---- hdl/srp_pkg.sv ----
/*
  Shared constants of the serial receive packetizer: register map,
  reset values, mode codes, buffer depth and timing counts.
  Assumes a single core clock at the rate given by CLK_HZ.
*/
package srp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_HZ      = 10_000_000;                 // Core clock rate
  localparam int POLL_US     = 20;                         // Longest poll interval, us
  localparam int POLL_CYC    = CLK_HZ / 1_000_000 * POLL_US; // Rounded down
  localparam int MS_PER_TICK = 1;                          // Timeout unit, ms
  localparam int MS_CYC      = CLK_HZ / 1000 * MS_PER_TICK;  // Cycles per ms

  ////////////////////////////////////////////////////////////////////////////
  // Buffer and transfer sizes
  localparam logic [7:0]  BUF_DEPTH  = 8'h80;   // Receive buffer, bytes
  localparam logic [15:0] MTU_HDR    = 16'h0003; // Per-transfer header bytes
  localparam logic [15:0] MTU_DEF    = 16'h0017; // Default transfer unit

  ////////////////////////////////////////////////////////////////////////////
  // Packetization modes
  typedef enum logic [7:0] {
    MODE_IMMEDIATE = 8'h00,
    MODE_ANTICIPATE = 8'h01,
    MODE_FIXED     = 8'h02,
    MODE_VARIABLE  = 8'h03,
    MODE_END_BYTE  = 8'h04
  } srp_mode_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_MODE   = 8'h01;    // Anticipate
  localparam logic [7:0] RST_WAIT   = 8'h05;    // 5 ms
  localparam logic [7:0] RST_LENGTH = 8'h14;    // 20 bytes
  localparam logic [7:0] RST_EOP    = 8'h0d;    // Carriage return

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (8-bit data)
  localparam logic [3:0] REG_MODE   = 4'h0;     // Mode field of the command
  localparam logic [3:0] REG_WAIT   = 4'h1;     // Timeout, ms
  localparam logic [3:0] REG_LENGTH = 4'h2;     // Target length, bytes
  localparam logic [3:0] REG_EOP    = 4'h3;     // End-of-packet byte
  localparam logic [3:0] REG_COUNT  = 4'h4;     // Buffered bytes, read only
  localparam logic [3:0] REG_STATE  = 4'h5;     // Engine state, read only

  ////////////////////////////////////////////////////////////////////////////
  // Send engine states, Gray along idle-send-link-send-idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_LINK = 2'b11
  } srp_state_t;

endpackage : srp_pkg

// ---- hdl/srp_tick_div.sv ----
/*
  Divider producing a one-cycle enable pulse every CYC core cycles.
  Assumes a synchronous clear from logic on the same clock.
*/
`timescale 1ns/1ns
module srp_tick_div #(
  parameter int CYC = 200                 // Cycles between pulses
) (
  input  wire logic clk,                  // Core clock
  input  wire logic arst_n,               // Asynchronous reset, active low
  input  wire logic clr,                  // Restart the count
  output logic      tick                  // One-cycle pulse
);

  localparam int W = (CYC > 1) ? $clog2(CYC) : 1;
  localparam logic [W-1:0] LAST = W'(CYC - 1);

  logic [W-1:0] cnt;                      // Cycles since last pulse

  // Count up, pulse on the last cycle, wrap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (clr) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == LAST);
      cnt  <= (cnt == LAST) ? '0 : cnt + W'(1);
    end
  end

endmodule : srp_tick_div

// ---- tb/srp_host_model.sv ----
/*
  Host model: offers queued bytes on the receive handshake, one at a time.
  Assumes the bench pushes bytes into q only after reset is released.
*/
`timescale 1ns/1ns
module srp_host_model (
  input  wire logic       clk,  // Core clock
  input  wire logic       rdy,  // Byte taken this edge
  output logic            vld,  // Byte offered
  output logic      [7:0] dat   // Offered byte
);
  logic [7:0] q[$];             // Bytes still to offer, count bytes included
  initial begin
    vld = 1'b0;
    dat = 8'h00;
  end
  // Hold a byte until taken; an idle data line toggles every cycle
  always @(posedge clk) begin
    if (!vld || rdy) begin
      if (q.size() != 0) begin
        vld <= 1'b1;
        dat <= q.pop_front();
      end else begin
        vld <= 1'b0;
        dat <= ~dat;
      end
    end
  end
endmodule : srp_host_model

// ---- tb/tb_top.sv ----
/*
  Bench: drives bytes through the host model, sinks link transfers with
  random stalls and compares them with a queue model of the modes.
*/
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_top;
  logic CORE_CLK = 0, ARST_N = 0, REG_WR = 0, REG_RD = 0, PIPE_OPEN = 0;
  logic LINK_READY = 1, TX_READY = 0, RX_VALID, RX_READY, BYP_VALID, TX_VALID, TX_LAST;
  logic [3:0] REG_ADDR = 0;
  logic [7:0] REG_WDATA = 0, REG_RDATA, RX_DATA, BYP_DATA, TX_DATA;
  logic [15:0] LINK_MTU = srp_pkg::MTU_DEF;
  int mismatches = 0, compares = 0, seed = 84, n = 0, lens[$], gl[$];
  logic [7:0] got[$], byp[$], b[$], e[$];
  srp_packetizer #(.MS_CYC(20)) srp_packetizer_i (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .PIPE_OPEN(PIPE_OPEN), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
    .RX_READY(RX_READY), .BYP_VALID(BYP_VALID), .BYP_DATA(BYP_DATA), .LINK_MTU(LINK_MTU),
    .LINK_READY(LINK_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST),
    .TX_READY(TX_READY));
  srp_host_model srp_host_model_i (.clk(CORE_CLK), .rdy(RX_READY), .vld(RX_VALID),
    .dat(RX_DATA));
  initial forever #50 CORE_CLK = ~CORE_CLK;
  // Link sink with random stalls; collects bytes and piece lengths
  always @(posedge CORE_CLK) begin
    TX_READY <= 1'($random(seed));
    if (BYP_VALID === 1'b1) byp.push_back(BYP_DATA);
    if (TX_VALID === 1'b1 && TX_READY === 1'b1) begin
      got.push_back(TX_DATA);
      n++;
      if (TX_LAST === 1'b1) begin
        gl.push_back(n);
        n = 0;
      end
    end
  end
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a; REG_WDATA <= d; REG_WR <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] x);
    @(posedge CORE_CLK);
    REG_ADDR <= a; REG_RD <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1 `CHK("reg", x, REG_RDATA)
  endtask : rd
  task fill(input int c, input bit r);
    b = {};
    for (int j = 0; j < c; j++) b.push_back(r ? 8'($random(seed)) : 8'(j + 1));
  endtask : fill
  // Build the expected stream from b, send b, wait for it and compare
  task run(input int m);
    int i, k, w;
    e = {};
    i = 0;
    while (i < b.size()) begin
      if (m == 3) begin
        k = (b[i] > 128) ? 128 : b[i];
        e = {e, b[i+1:i+k]};
        i += k + 1;
      end else begin
        e.push_back(b[i]);
        i++;
      end
    end
    foreach (b[j]) srp_host_model_i.q.push_back(b[j]);
    w = 0;
    while (got.size() < e.size() && w < 5000) begin
      @(posedge CORE_CLK);
      w++;
    end
    repeat (300) @(posedge CORE_CLK);
    `CHK("count", e.size(), got.size())
    foreach (e[j]) `CHK("byte", e[j], got[j])
    if (lens.size() != 0) `CHK("pieces", lens.size(), gl.size())
    foreach (lens[j]) `CHK("piece", lens[j], gl[j])
    got = {};
    gl = {};
    $display("test mode %0d done", m);
  endtask : run
  task finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Watchdog cuts a hang short
  initial begin
    repeat (60000) @(posedge CORE_CLK);
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    rd(4'h0, 8'h01);
    rd(4'h1, 8'h05);
    rd(4'h2, 8'h14);
    rd(4'h3, 8'h0d);
    rd(4'h9, 8'h00);
    srp_host_model_i.q = {8'h41, 8'h42};
    repeat (20) @(posedge CORE_CLK);
    `CHK("bypass", 16'h4142, {byp[0], byp[1]})
    `CHK("nosend", 0, got.size())
    PIPE_OPEN <= 1'b1;
    wr(4'h0, 8'h02); wr(4'h2, 8'h20);
    fill(32, 1); lens = {20, 12}; run(2);
    wr(4'h0, 8'h03);
    b = {8'h05, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h03, 8'h66, 8'h67, 8'h68};
    lens = {5, 3}; run(3);
    fill(128, 1); b.push_front(8'hc8); lens = {20, 20, 20, 20, 20, 20, 8}; run(3);
    wr(4'h0, 8'h04); wr(4'h3, 8'h7e);
    fill(5, 0); b.push_back(8'h7e); lens = {6}; run(4);
    fill(20, 0); lens = {20}; run(4);
    wr(4'h3, 8'hff); LINK_MTU <= 16'h00c8;
    fill(128, 0); lens = {128}; run(4);
    LINK_MTU <= srp_pkg::MTU_DEF;
    wr(4'h0, 8'h01); wr(4'h1, 8'hff); wr(4'h2, 8'h14);
    fill(20, 0); lens = {20}; run(1);
    wr(4'h1, 8'h02);
    fill(3, 1); lens = {3}; run(1);
    wr(4'h0, 8'h00);
    fill(10, 1); lens = {}; run(0);
    finish_test;
  end
endmodule : tb_top
